//--- shared/ucs_pkg.sv
// Shared constants and types for the user control store block.
// Assumes a 100 MHz mclk; microaddresses are 11 bits wide.
package ucs_pkg;
  // Clock and the bus reply deadline
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BUS_TIMEOUT_NS = 10000;
  localparam int unsigned BUS_TIMEOUT_CYC = (BUS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMO_W = 10;
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(BUS_TIMEOUT_CYC - 1);

  // Store geometry and placement
  localparam int UADDR_W = 11;
  localparam int STORE_IDX_W = 10;
  localparam int STORE_DEPTH = 1024;
  localparam int WORD_W = 24;
  localparam int TRACE_CTL_BIT = 23;
  localparam logic [UADDR_W-1:0] STORE_BASE = 11'h400;
  localparam logic [UADDR_W-1:0] STORE_LAST = 11'h7FF;
  localparam logic [UADDR_W-1:0] RSV_LAST = 11'h5FF;

  // Trace buffer
  localparam int TRACE_DEPTH = 16;
  localparam int TRACE_IDX_W = 4;

  // Fixed opcode classification and routine entry points
  localparam logic [15:0] USER_OP_MASK = 16'hFFC0;
  localparam logic [15:0] USER_OP_BASE = 16'h7DC0;
  localparam logic [15:0] OP_PUSH = 16'h7DC0;
  localparam logic [15:0] OP_POP = 16'h7DC1;
  localparam logic [UADDR_W-1:0] ENTRY_PUSH = 11'h600;
  localparam logic [UADDR_W-1:0] ENTRY_POP = 11'h620;
  localparam logic [UADDR_W-1:0] ENTRY_BLOCK_MOVE_OP = 11'h640;
  localparam logic [UADDR_W-1:0] ENTRY_OTHER = 11'h660;

  // Traps and program counter
  localparam logic [15:0] BUS_ERR_VECTOR = 16'h0008;
  localparam logic [15:0] PC_STEP = 16'h0002;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // Status word low byte layout
  localparam int FLAG_LSB = 0;
  localparam int TRACE_POS = 4;
  localparam int IE_POS = 7;
  localparam logic [7:0] SHADOW_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  typedef enum logic [1:0] {
    ST_FETCH,
    ST_STD_EXEC,
    ST_USER_EXEC,
    ST_SERVICE
  } ucs_cycle_type;
endpackage

//--- rtl/ucs_trace_buffer.sv
// Recirculating microaddress trace buffer of the user control store.
// Assumes capture strobes are synchronous to mclk and qualified upstream.
`timescale 1ns/1ns
module ucs_trace_buffer (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Capture side
  input wire logic cap_valid,
  input wire logic [ucs_pkg::UADDR_W-1:0] cap_addr,
  input wire logic [ucs_pkg::UADDR_W-1:0] stop_addr,
  input wire logic rearm,
  // Read side, index 0 is the oldest entry
  input wire logic [ucs_pkg::TRACE_IDX_W-1:0] rd_idx,
  output logic [ucs_pkg::UADDR_W-1:0] rd_data,
  output logic done
);
  typedef struct packed {
    logic [ucs_pkg::TRACE_IDX_W-1:0] wr_ptr;
    logic done;
    logic [ucs_pkg::UADDR_W-1:0] rd_data;
  } ucs_trace_state_type;

  ucs_trace_state_type st_ff;
  ucs_trace_state_type nxt_st;
  logic [ucs_pkg::UADDR_W-1:0] entry_ff [ucs_pkg::TRACE_DEPTH];
  logic take;

  // Frozen once the designated address lands, until software rearms
  assign take = cap_valid && !st_ff.done;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_data = entry_ff[st_ff.wr_ptr + rd_idx];
    if (rearm) begin
      nxt_st.done = 1'b0;
    end
    if (take) begin
      nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
      // A stop hit in the rearm cycle still wins
      if (cap_addr == stop_addr) begin
        nxt_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Oldest entry is overwritten; no reset needed for the contents
  always_ff @(posedge mclk) begin
    if (take) begin
      entry_ff[st_ff.wr_ptr] <= cap_addr;
    end
  end

  assign rd_data = st_ff.rd_data;
  assign done = st_ff.done;
endmodule

//--- rtl/ucs_control_store.sv
// Writable microstore with its machine-cycle, trap, status and trace logic.
// Assumes one synchronous mclk domain and a loader that writes the store.
`timescale 1ns/1ns
module ucs_control_store (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Store loader
  input wire logic load_we,
  input wire logic [ucs_pkg::STORE_IDX_W-1:0] load_addr,
  input wire logic [ucs_pkg::WORD_W-1:0] load_data,
  // Micro instruction bus
  input wire logic mib_valid,
  input wire logic [ucs_pkg::UADDR_W-1:0] mib_addr,
  output logic mib_hit,
  output logic [ucs_pkg::WORD_W-1:0] mib_data,
  output logic rsv_trap,
  // Machine instruction fetch and sequencing
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [15:0] pc_in,
  input wire logic block_move_select,
  input wire logic std_done,
  input wire logic routine_done,
  input wire logic refetch_req,
  output logic dispatch_valid,
  output logic [ucs_pkg::UADDR_W-1:0] dispatch_addr,
  output logic [15:0] pc_out,
  output logic [1:0] cycle_state,
  // System bus reply watch
  input wire logic bus_start,
  input wire logic bus_reply,
  input wire logic berr_arm,
  output logic bus_err_trap,
  output logic berr_prepared,
  output logic [15:0] trap_vector,
  // Interrupts
  input wire logic ext_irq,
  input wire logic event_irq,
  output logic irq_pending,
  output logic intr_ack,
  // Status flags
  input wire logic flag_load_op,
  input wire logic [3:0] flag_load_val,
  input wire logic flag_copy_op,
  input wire logic alu_flag_we,
  input wire logic [3:0] alu_flags,
  input wire logic set_control_flag_op,
  input wire logic clear_control_flag_op,
  input wire logic control_flag_sel,
  output logic [3:0] flag_copy_val,
  output logic [7:0] status_shadow_low_reg,
  // Trace buffer access
  input wire logic [ucs_pkg::UADDR_W-1:0] trace_stop_addr,
  input wire logic trace_rearm,
  input wire logic [ucs_pkg::TRACE_IDX_W-1:0] trace_rd_idx,
  output logic [ucs_pkg::UADDR_W-1:0] trace_rd_data,
  output logic trace_done
);
  typedef struct packed {
    ucs_pkg::ucs_cycle_type cyc;
    logic mib_hit;
    logic [ucs_pkg::WORD_W-1:0] mib_data;
    logic rsv_trap;
    logic dispatch_valid;
    logic [ucs_pkg::UADDR_W-1:0] dispatch_addr;
    logic [15:0] pc;
    logic bus_busy;
    logic [ucs_pkg::TMO_W-1:0] tmo_cnt;
    logic berr_flag;
    logic bus_err_trap;
    logic berr_prepared;
    logic [15:0] trap_vector;
    logic intr_ack;
    logic [3:0] flags;
    logic [3:0] flag_copy;
    logic trace_en;
    logic intr_en;
  } ucs_core_state_type;

  ucs_core_state_type st_ff;
  ucs_core_state_type nxt_st;
  logic [ucs_pkg::WORD_W-1:0] store_ff [ucs_pkg::STORE_DEPTH];
  logic [ucs_pkg::STORE_IDX_W-1:0] mib_idx;
  logic hit;
  logic trace_cap;
  logic tmo_hit;

  function automatic logic in_range(input logic [ucs_pkg::UADDR_W-1:0] a,
                                    input logic [ucs_pkg::UADDR_W-1:0] lo,
                                    input logic [ucs_pkg::UADDR_W-1:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Fixed translation, not alterable by the user
  function automatic logic [ucs_pkg::UADDR_W-1:0] entry_of(input logic [15:0] op,
                                                           input logic blk_sel);
    if (op == ucs_pkg::OP_PUSH) begin
      entry_of = blk_sel ? ucs_pkg::ENTRY_BLOCK_MOVE_OP : ucs_pkg::ENTRY_PUSH;
    end else if (op == ucs_pkg::OP_POP) begin
      entry_of = ucs_pkg::ENTRY_POP;
    end else begin
      entry_of = ucs_pkg::ENTRY_OTHER;
    end
  endfunction

  assign hit = mib_valid && in_range(mib_addr, ucs_pkg::STORE_BASE, ucs_pkg::STORE_LAST);
  assign mib_idx = mib_addr[ucs_pkg::STORE_IDX_W-1:0];
  // Only user microcode marked by its top stored bit lands in the trace
  assign trace_cap = hit && store_ff[mib_idx][ucs_pkg::TRACE_CTL_BIT];
  assign tmo_hit = st_ff.bus_busy && !bus_reply && (st_ff.tmo_cnt == ucs_pkg::TMO_LAST);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.mib_hit = hit;
    nxt_st.mib_data = hit ? store_ff[mib_idx] : '0;
    nxt_st.rsv_trap = mib_valid
                      && in_range(mib_addr, ucs_pkg::STORE_BASE, ucs_pkg::RSV_LAST);
    nxt_st.dispatch_valid = 1'b0;
    nxt_st.bus_err_trap = 1'b0;
    nxt_st.intr_ack = 1'b0;

    // Reply watch; the device side answering is what stops the count
    if (bus_start) begin
      nxt_st.bus_busy = 1'b1;
      nxt_st.tmo_cnt = '0;
    end else if (st_ff.bus_busy) begin
      if (bus_reply) begin
        nxt_st.bus_busy = 1'b0;
      end else if (tmo_hit) begin
        nxt_st.bus_busy = 1'b0;
        nxt_st.bus_err_trap = 1'b1;
        nxt_st.berr_prepared = st_ff.berr_flag;
        nxt_st.trap_vector = ucs_pkg::BUS_ERR_VECTOR;
      end else begin
        nxt_st.tmo_cnt = st_ff.tmo_cnt + 1'b1;
      end
    end
    // Arming after the trap consumed the flag keeps it armed
    if (tmo_hit && !bus_start) begin
      nxt_st.berr_flag = 1'b0;
    end
    if (berr_arm) begin
      nxt_st.berr_flag = 1'b1;
    end

    case (st_ff.cyc)
      ucs_pkg::ST_FETCH: begin
        if (instr_valid) begin
          nxt_st.pc = pc_in;
          if ((instr & ucs_pkg::USER_OP_MASK) == ucs_pkg::USER_OP_BASE) begin
            nxt_st.cyc = ucs_pkg::ST_USER_EXEC;
            nxt_st.dispatch_valid = 1'b1;
            nxt_st.dispatch_addr = entry_of(instr, block_move_select);
          end else begin
            nxt_st.cyc = ucs_pkg::ST_STD_EXEC;
          end
        end
      end
      ucs_pkg::ST_STD_EXEC: begin
        if (std_done) begin
          nxt_st.cyc = ucs_pkg::ST_SERVICE;
        end
      end
      ucs_pkg::ST_USER_EXEC: begin
        if (refetch_req) begin
          nxt_st.pc = st_ff.pc - ucs_pkg::PC_STEP;
          nxt_st.cyc = ucs_pkg::ST_SERVICE;
        end else if (routine_done) begin
          nxt_st.cyc = ucs_pkg::ST_SERVICE;
        end
      end
      ucs_pkg::ST_SERVICE: begin
        // Latency grows with the execute phase: no earlier acceptance
        nxt_st.intr_ack = st_ff.intr_en && (ext_irq || event_irq);
        nxt_st.cyc = ucs_pkg::ST_FETCH;
      end
      default: begin
        nxt_st.cyc = ucs_pkg::ST_FETCH;
      end
    endcase
    // A missing reply aborts execution into the service step
    if (tmo_hit && (st_ff.cyc != ucs_pkg::ST_FETCH)) begin
      nxt_st.cyc = ucs_pkg::ST_SERVICE;
    end

    // Explicit load beats the implicit update in the same cycle
    if (flag_load_op) begin
      nxt_st.flags = flag_load_val;
    end else if (alu_flag_we) begin
      nxt_st.flags = alu_flags;
    end
    if (flag_copy_op) begin
      nxt_st.flag_copy = st_ff.flags;
    end

    if (set_control_flag_op) begin
      if (control_flag_sel) begin
        nxt_st.intr_en = 1'b1;
      end else begin
        nxt_st.trace_en = 1'b1;
      end
    end else if (clear_control_flag_op) begin
      if (control_flag_sel) begin
        nxt_st.intr_en = 1'b0;
      end else begin
        nxt_st.trace_en = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.cyc <= ucs_pkg::ST_FETCH;
      st_ff.pc <= ucs_pkg::PC_RESET;
      st_ff.flags <= ucs_pkg::FLAGS_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Volatile store; contents are undefined until loaded
  always_ff @(posedge mclk) begin
    if (load_we) begin
      store_ff[load_addr] <= load_data;
    end
  end

  ucs_trace_buffer u_trace (
    .mclk(mclk),
    .rst_n(rst_n),
    .cap_valid(trace_cap),
    .cap_addr(mib_addr),
    .stop_addr(trace_stop_addr),
    .rearm(trace_rearm),
    .rd_idx(trace_rd_idx),
    .rd_data(trace_rd_data),
    .done(trace_done)
  );

  always_comb begin
    status_shadow_low_reg = ucs_pkg::SHADOW_RESET;
    status_shadow_low_reg[ucs_pkg::FLAG_LSB +: 4] = st_ff.flags;
    status_shadow_low_reg[ucs_pkg::TRACE_POS] = st_ff.trace_en;
    status_shadow_low_reg[ucs_pkg::IE_POS] = st_ff.intr_en;
  end

  // Mid-routine test is combinational so microcode sees it at once
  assign irq_pending = ext_irq || event_irq;
  assign mib_hit = st_ff.mib_hit;
  assign mib_data = st_ff.mib_data;
  assign rsv_trap = st_ff.rsv_trap;
  assign dispatch_valid = st_ff.dispatch_valid;
  assign dispatch_addr = st_ff.dispatch_addr;
  assign pc_out = st_ff.pc;
  assign cycle_state = st_ff.cyc;
  assign bus_err_trap = st_ff.bus_err_trap;
  assign berr_prepared = st_ff.berr_prepared;
  assign trap_vector = st_ff.trap_vector;
  assign intr_ack = st_ff.intr_ack;
  assign flag_copy_val = st_ff.flag_copy;
endmodule

//--- verif/ucs_bus_device.sv
// Behavioural system-bus device that answers each transfer with a reply.
// Assumes one transfer at a time; mute models an absent device.
`timescale 1ns/1ns
module ucs_bus_device (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Transfer control
  input wire logic bus_start,
  input wire logic mute,
  input wire logic [7:0] reply_lat,
  // Reply
  output logic bus_reply
);
  logic [7:0] cnt_ff;
  logic busy_ff;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      busy_ff <= 1'h0;
      cnt_ff <= 8'h00;
      bus_reply <= 1'h0;
    end else begin
      bus_reply <= 1'h0;
      if (bus_start) begin
        busy_ff <= 1'h1;
        cnt_ff <= reply_lat;
      end else if (busy_ff && cnt_ff == 8'h00) begin
        busy_ff <= 1'h0;
        bus_reply <= !mute;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
endmodule

//--- verif/ucs_checker.sv
// Port-level assertions for the user control store.
// Assumes it is bound onto ucs_control_store in the single mclk domain.
`timescale 1ns/1ns
module ucs_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Store bus and sequencer
  input wire logic mib_valid,
  input wire logic [ucs_pkg::UADDR_W-1:0] mib_addr,
  input wire logic mib_hit,
  input wire logic [ucs_pkg::WORD_W-1:0] mib_data,
  input wire logic rsv_trap,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic routine_done,
  input wire logic refetch_req,
  input wire logic dispatch_valid,
  input wire logic [15:0] pc_out,
  input wire logic [1:0] cycle_state,
  // Bus watch, interrupts, flags, trace
  input wire logic bus_start,
  input wire logic bus_reply,
  input wire logic bus_err_trap,
  input wire logic [15:0] trap_vector,
  input wire logic intr_ack,
  input wire logic flag_load_op,
  input wire logic [3:0] flag_load_val,
  input wire logic set_control_flag_op,
  input wire logic control_flag_sel,
  input wire logic [7:0] status_shadow_low_reg,
  input wire logic trace_done,
  input wire logic trace_rearm
);
  // Start edge counts as 1, so the trap is seen one edge after the 1000th
  localparam int TMO_SEEN = 1001;
  int wait_ff;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wait_ff <= 0;
    end else if (bus_start) begin
      wait_ff <= 1;
    end else if (bus_reply) begin
      wait_ff <= 0;
    end else if (wait_ff != 0 && wait_ff < 2000) begin
      wait_ff <= wait_ff + 1;
    end
  end
  a_hit_map: assert property (mib_valid |=> mib_hit == $past(mib_addr[10]))
    else $error("store hit does not follow address window");
  a_miss_zero: assert property (mib_valid && !mib_addr[10] |=> mib_data == 24'h000000)
    else $error("store drives data outside its window");
  a_rsv_trap: assert property (mib_valid && mib_addr[10:9] == 2'h2 |=> rsv_trap)
    else $error("reserved entry not trapped");
  a_user_disp: assert property (cycle_state == 2'h0 && instr_valid &&
    (instr & ucs_pkg::USER_OP_MASK) == ucs_pkg::USER_OP_BASE |=> dispatch_valid
    && cycle_state == 2'h2) else $error("user opcode not dispatched");
  a_done_svc: assert property (cycle_state == 2'h2 && (routine_done || refetch_req)
    |=> cycle_state == 2'h3 ##1 cycle_state == 2'h0) else $error("routine end skips service");
  a_refetch_pc: assert property (cycle_state == 2'h2 && refetch_req
    |=> pc_out == $past(pc_out) - 16'h0002) else $error("refetch did not step back");
  a_ack_svc: assert property (intr_ack |-> $past(cycle_state) == 2'h3)
    else $error("interrupt taken outside service step");
  a_flag_load: assert property (flag_load_op |=> status_shadow_low_reg[3:0] == $past(flag_load_val))
    else $error("flag load lost");
  a_ie_set: assert property (set_control_flag_op && control_flag_sel |=> status_shadow_low_reg[7])
    else $error("enable shadow not set");
  a_berr_time: assert property (wait_ff == TMO_SEEN |-> bus_err_trap
    ##1 trap_vector == ucs_pkg::BUS_ERR_VECTOR) else $error("missing bus error trap");
  a_berr_cause: assert property (bus_err_trap |-> wait_ff == TMO_SEEN)
    else $error("bus error trap at wrong time");
  a_trace_hold: assert property (trace_done && !trace_rearm |=> trace_done)
    else $error("trace capture restarted");
  c_disp: cover property (dispatch_valid);
  c_berr: cover property (bus_err_trap);
  c_ack: cover property (intr_ack);
  c_trace: cover property ($rose(trace_done));
endmodule

//--- verif/tb.sv
// Self-checking bench for the user control store block.
// Assumes the bus device model as far side and a 100 MHz mclk.
`timescale 1ns/1ns
module tb;
  logic mclk = 1'h0;
  logic rst_n = 1'h0, load_we = 1'h0, mib_valid = 1'h0, instr_valid = 1'h0, mute = 1'h0;
  logic block_move_select = 1'h0, std_done = 1'h0, routine_done = 1'h0, refetch_req = 1'h0;
  logic bus_start = 1'h0, berr_arm = 1'h0, ext_irq = 1'h0, event_irq = 1'h0;
  logic flag_load_op = 1'h0, flag_copy_op = 1'h0, alu_flag_we = 1'h0, trace_rearm = 1'h0;
  logic set_control_flag_op = 1'h0, clear_control_flag_op = 1'h0, control_flag_sel = 1'h0;
  logic [9:0] load_addr = 10'h000;
  logic [23:0] load_data = 24'h000000;
  logic [10:0] mib_addr = 11'h000, trace_stop_addr = 11'h000;
  logic [15:0] instr = 16'h0000, pc_in = 16'h0000;
  logic [3:0] flag_load_val = 4'h0, alu_flags = 4'h0, trace_rd_idx = 4'h0;
  logic [7:0] reply_lat = 8'h00;
  logic bus_reply, mib_hit, rsv_trap, dispatch_valid, bus_err_trap, berr_prepared;
  logic irq_pending, intr_ack, trace_done;
  logic [23:0] mib_data;
  logic [10:0] dispatch_addr, trace_rd_data;
  logic [15:0] pc_out, trap_vector;
  logic [1:0] cycle_state;
  logic [3:0] flag_copy_val;
  logic [7:0] status_shadow_low_reg;
  logic [10:0] adr_tab [5] = '{11'h3FF, 11'h400, 11'h5FF, 11'h600, 11'h7FF};
  logic [15:0] op_tab [4] = '{16'h7DC0, 16'h7DC1, 16'h7DC0, 16'h7DC5};
  logic sel_tab [4] = '{1'h0, 1'h0, 1'h1, 1'h0};
  logic [10:0] ent_tab [4] = '{11'h600, 11'h620, 11'h640, 11'h660};
  int n_mismatch = 0, cmp_count = 0, n_berr = 0;
  initial begin
    forever #5 mclk = ~mclk;
  end
  ucs_control_store i_dut (.*);
  ucs_bus_device i_dev (.mclk(mclk), .rst_n(rst_n), .bus_start(bus_start), .mute(mute),
    .reply_lat(reply_lat), .bus_reply(bus_reply));
  always @(negedge mclk) if (bus_err_trap === 1'h1) n_berr++;
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask
  // Strobe stays up across back-to-back calls; the caller drops it after the last
  task automatic micro_instruction_bus(input logic [10:0] a);
    mib_addr = a;
    mib_valid = 1'h1;
    tick(1);
  endtask
  task automatic load(input logic [9:0] a, input logic [23:0] d);
    load_addr = a;
    load_data = d;
    load_we = 1'h1;
    tick(1);
  endtask
  task automatic run_op(input logic [15:0] op, input logic sel, input logic [10:0] ent);
    instr = op;
    block_move_select = sel;
    pc_in = 16'h0100;
    pulse(instr_valid);
    chk(dispatch_valid, 1'h1);
    chk(dispatch_addr, ent);
    chk(cycle_state, 2'h2);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Whole run needs about 3200 cycles
  initial begin
    repeat (6000) @(posedge mclk);
    n_mismatch++;
    $display("ERROR t=%0t watchdog got=%h exp=%h", $time, 1'h0, 1'h1);
    final_report();
  end
  initial begin
    tick(16);
    rst_n = 1'h1;
    load(10'h000, 24'h80ABCD);
    load(10'h3FF, 24'h123456);
    load_we = 1'h0;
    foreach (adr_tab[i]) begin
      micro_instruction_bus(adr_tab[i]);
      chk(mib_hit, adr_tab[i][10]);
      chk(rsv_trap, adr_tab[i][10:9] == 2'h2);
    end
    micro_instruction_bus(11'h400);
    chk(mib_data, 24'h80ABCD);
    micro_instruction_bus(11'h7FF);
    chk(mib_data, 24'h123456);
    mib_valid = 1'h0;
    $display("store test done");
    foreach (op_tab[i]) begin
      run_op(op_tab[i], sel_tab[i], ent_tab[i]);
      pulse(routine_done);
      chk(cycle_state, 2'h3);
      tick(1);
      chk(cycle_state, 2'h0);
    end
    instr = 16'h0A00;
    pulse(instr_valid);
    chk(dispatch_valid, 1'h0);
    chk(cycle_state, 2'h1);
    pulse(std_done);
    tick(1);
    $display("dispatch test done");
    control_flag_sel = 1'h1;
    set_control_flag_op = 1'h1;
    tick(1);
    control_flag_sel = 1'h0;
    pulse(set_control_flag_op);
    chk(status_shadow_low_reg, 8'h90);
    pulse(clear_control_flag_op);
    chk(status_shadow_low_reg, 8'h80);
    flag_load_val = 4'hA;
    alu_flags = 4'h5;
    alu_flag_we = 1'h1;
    pulse(flag_load_op);
    chk(status_shadow_low_reg, 8'h8A);
    tick(1);
    alu_flag_we = 1'h0;
    chk(status_shadow_low_reg, 8'h85);
    pulse(flag_copy_op);
    chk(flag_copy_val, 4'h5);
    event_irq = 1'h1;
    run_op(16'h7DC1, 1'h0, 11'h620);
    chk(irq_pending, 1'h1);
    tick(3);
    chk(intr_ack, 1'h0);
    pulse(refetch_req);
    chk(cycle_state, 2'h3);
    chk(pc_out, 16'h00FE);
    tick(1);
    chk(intr_ack, 1'h1);
    event_irq = 1'h0;
    ext_irq = 1'h1;
    tick(1);
    chk(irq_pending, 1'h1);
    ext_irq = 1'h0;
    tick(1);
    chk(irq_pending, 1'h0);
    control_flag_sel = 1'h1;
    pulse(clear_control_flag_op);
    chk(status_shadow_low_reg, 8'h05);
    $display("status and interrupt test done");
    reply_lat = 8'h14;
    pulse(bus_start);
    tick(1100);
    chk(n_berr, 0);
    mute = 1'h1;
    pulse(berr_arm);
    pulse(bus_start);
    tick(ucs_pkg::BUS_TIMEOUT_CYC - 1);
    chk(bus_err_trap, 1'h0);
    tick(1);
    chk(bus_err_trap, 1'h1);
    chk(berr_prepared, 1'h1);
    tick(1);
    chk(trap_vector, 16'h0008);
    // The first trap used up the armed flag, so this one reports unprepared
    pulse(bus_start);
    tick(ucs_pkg::BUS_TIMEOUT_CYC);
    chk(bus_err_trap, 1'h1);
    chk(berr_prepared, 1'h0);
    mute = 1'h0;
    $display("bus timeout test done");
    for (int i = 0; i < 20; i++) load(10'(i), 24'h800000 + 24'(i));
    load(10'h014, 24'h000000);
    load_we = 1'h0;
    trace_stop_addr = 11'h413;
    pulse(trace_rearm);
    chk(trace_done, 1'h0);
    for (int i = 0; i < 20; i++) begin
      if (i == 10) micro_instruction_bus(11'h414);
      micro_instruction_bus(11'h400 + 11'(i));
    end
    chk(trace_done, 1'h1);
    micro_instruction_bus(11'h400);
    mib_valid = 1'h0;
    for (int i = 0; i < 16; i++) begin
      trace_rd_idx = 4'(i);
      tick(1);
      chk(trace_rd_data, 11'h404 + 11'(i));
    end
    pulse(trace_rearm);
    chk(trace_done, 1'h0);
    $display("trace test done");
    final_report();
  end
endmodule
bind ucs_control_store ucs_checker i_chk (.*);
